// [verification/brsc_top_tb.sv]
// Self-checking bench for the buck set point and configuration bank
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module brsc_top_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] r;
    } brsc_row_s;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    brsc_pkg::brsc_pwr_e pwr = brsc_pkg::PWR_NORMAL;
    brsc_pkg::brsc_cfg_s cfg;
    brsc_pkg::brsc_target_s tgt;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    // Write a row, read it back: unused bits must come back zero
    brsc_row_s rows [5] = '{'{8'h80, 8'hff, 8'h3f}, '{8'h84, 8'hcd, 8'h0d},
        '{8'h88, 8'h6a, 8'h2a}, '{8'h8c, 8'hff, 8'h2f},
        '{8'h90, 8'ha6, 8'ha6}};
    logic [11:0] fk [4] = '{12'h3e8, 12'h7d0, 12'hfa0, 12'h000};
    logic [8:0] ph [4] = '{9'h000, 9'h05a, 9'h0b4, 9'h10e};
    logic [11:0] rc [4] = '{12'h190, 12'h320, 12'h640, 12'hc80};
    logic [5:0] cd [3] = '{6'h3f, 6'h0d, 6'h0e};

    brsc_top DUT (
        .SYS_CLK(clk),
        .SYS_RST(rst),
        .CLK_EN(clk_en),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PSTRB(pstrb),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .POWER_STATE(pwr),
        .CFG_OUT(cfg),
        .TARGET_OUT(tgt)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB master: setup, access held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic [3:0] st);
        int n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            pstrb <= st;
            @(posedge clk);
            penable <= 1'b1;
            do begin
                @(posedge clk);
                n++;
            end while (pready !== 1'b1 && n < 50);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 50)
                n_errors++;
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        begin
            apb(1'b0, a, 8'h00, 4'h0);
            `CHK(rd, e)
            `CHK(er, ee)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rdchk(8'h80 + 8'(4 * i), 32'h0, 1'b0);
        `CHK(cfg.freq_khz, 12'h3e8)
        `CHK(cfg.ramp_step_cycles, 12'h190)
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, {24'h0, rows[i].r}, 1'b0);
        end
        rdchk(8'h84, 32'h0d, 1'b0);
        rdchk(8'h88, 32'h2a, 1'b0);
        $display("test register rows done");
        // Strobe off, unmapped and misaligned accesses
        apb(1'b1, 8'h90, 8'h00, 4'h0);
        rdchk(8'h90, 32'ha6, 1'b0);
        apb(1'b1, 8'h94, 8'hff, 4'h1);
        `CHK(er, 1'b1)
        rdchk(8'h94, 32'h0, 1'b1);
        rdchk(8'h82, 32'h0, 1'b1);
        $display("test refused accesses done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h90, {i[1:0], i[1:0], i[1:0], 1'b0, i[0]});
            repeat (2) @(posedge clk);
            `CHK(cfg.freq_khz, fk[i])
            `CHK(cfg.freq_reserved, 1'(i == 3))
            `CHK(cfg.phase_deg, ph[i])
            `CHK(cfg.ramp_step_cycles, rc[i])
            `CHK(cfg.current_limit_low, i[0])
            `CHK(cfg.switch_freq_sel, i[1:0])
            `CHK(cfg.clock_phase_sel, i[1:0])
            `CHK(cfg.ramp_speed_sel, i[1:0])
        end
        $display("test config decode done");
        // Only supported codes are programmed
        wr(8'h80, 8'h3f);
        wr(8'h84, 8'h0d);
        wr(8'h88, 8'h0e);
        wr(8'h8c, 8'h05);
        for (int p = 0; p < 3; p++) begin
            pwr <= brsc_pkg::brsc_pwr_e'(p);
            repeat (3) @(posedge clk);
            `CHK(tgt.code, cd[p])
            `CHK(tgt.mv, 11'h12c + 11'h019 * 11'(cd[p]))
            `CHK(tgt.enable, 1'(p != 2))
            `CHK(tgt.low_code, 1'(cd[p] <= 6'h0c))
            `CHK(tgt.mode, 4'h5)
        end
        wr(8'h8c, 8'h25);
        repeat (3) @(posedge clk);
        `CHK(tgt.enable, 1'b1)
        `CHK(tgt.pfm, 1'b1)
        $display("test power state target done");
        // Enable low: a power state change waits until it returns
        clk_en <= 1'b0;
        pwr <= brsc_pkg::PWR_NORMAL;
        repeat (3) @(posedge clk);
        `CHK(tgt.code, 6'h0e)
        clk_en <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(tgt.code, 6'h3f)
        $display("test clock enable freeze done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h80, 32'h0, 1'b0);
        rdchk(8'h90, 32'h0, 1'b0);
        `CHK(tgt.mv, 11'h12c)
        `CHK(tgt.low_code, 1'b1)
        $display("test mid-run reset done");
        final_report();
    end
endmodule

// [verilog/brsc_map.svh]
// Offsets, field positions, reset values and timing of the buck set point bank
`ifndef BRSC_MAP_SVH
`define BRSC_MAP_SVH

// Register indices; the APB byte address is the index times four
`define BRSC_IDX_NORMAL 6'h20
`define BRSC_IDX_STANDBY 6'h21
`define BRSC_IDX_SLEEP 6'h22
`define BRSC_IDX_MODE 6'h23
`define BRSC_IDX_CONFIG 6'h24

// Field positions
`define BRSC_CODE_MSB 5
`define BRSC_CODE_LSB 0
`define BRSC_MODE_MSB 3
`define BRSC_MODE_LSB 0
`define BRSC_SLEEP_RUN_BIT 5
`define BRSC_ILIM_BIT 0
`define BRSC_SPARE_BIT 1
`define BRSC_FREQ_MSB 3
`define BRSC_FREQ_LSB 2
`define BRSC_PHASE_MSB 5
`define BRSC_PHASE_LSB 4
`define BRSC_RAMP_MSB 7
`define BRSC_RAMP_LSB 6

// Reset values
`define BRSC_RST_CODE 6'h00
`define BRSC_RST_MODE 4'h0
`define BRSC_RST_BIT 1'b0
`define BRSC_RST_FIELD 2'h0

// Set point code to millivolts
`define BRSC_MV_BASE 11'h12c
`define BRSC_MV_STEP 11'h019
`define BRSC_LOW_CODE_MAX 6'h0c

// Switching frequency in kHz, clock phase in degrees
`define BRSC_FREQ_KHZ_0 12'h3e8
`define BRSC_FREQ_KHZ_1 12'h7d0
`define BRSC_FREQ_KHZ_2 12'hfa0
`define BRSC_PHASE_DEG_1 9'h05a
`define BRSC_PHASE_DEG_2 9'h0b4
`define BRSC_PHASE_DEG_3 9'h10e

// Ramp step period: time in ns and derived cycles at the system clock
`define BRSC_CLK_MHZ 200
`define BRSC_RAMP_T0_NS 2000
`define BRSC_RAMP_T1_NS 4000
`define BRSC_RAMP_T2_NS 8000
`define BRSC_RAMP_T3_NS 16000
`define BRSC_RAMP_C0 ((`BRSC_RAMP_T0_NS * `BRSC_CLK_MHZ + 999) / 1000)
`define BRSC_RAMP_C1 ((`BRSC_RAMP_T1_NS * `BRSC_CLK_MHZ + 999) / 1000)
`define BRSC_RAMP_C2 ((`BRSC_RAMP_T2_NS * `BRSC_CLK_MHZ + 999) / 1000)
`define BRSC_RAMP_C3 ((`BRSC_RAMP_T3_NS * `BRSC_CLK_MHZ + 999) / 1000)

`endif

// [verilog/brsc_pkg.sv]
// Types shared by the buck set point bank
package brsc_pkg;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_STANDBY,
        PWR_SLEEP
    } brsc_pwr_e;

    typedef struct packed {
        logic [5:0] normal_code;
        logic [5:0] standby_code;
        logic [5:0] sleep_code;
        logic [3:0] switch_mode_sel;
        logic sleep_run_sel;
        logic current_limit_low;
        logic cfg_spare;
        logic [1:0] switch_freq_sel;
        logic [1:0] clock_phase_sel;
        logic [1:0] ramp_speed_sel;
    } brsc_regs_s;

    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } brsc_apb_rsp_s;

    typedef struct packed {
        logic current_limit_low;
        logic [1:0] switch_freq_sel;
        logic freq_reserved;
        logic [11:0] freq_khz;
        logic [1:0] clock_phase_sel;
        logic [8:0] phase_deg;
        logic [1:0] ramp_speed_sel;
        logic [11:0] ramp_step_cycles;
    } brsc_cfg_s;

    typedef struct packed {
        brsc_regs_s regs;
        brsc_apb_rsp_s rsp;
        brsc_cfg_s cfg;
    } brsc_state_s;

    typedef struct packed {
        logic [5:0] code;
        logic [10:0] mv;
        logic enable;
        logic pfm;
        logic [3:0] mode;
        logic low_code;
    } brsc_target_s;

endpackage

// [verilog/brsc_target.sv]
// Active set point selection from the device power state
`timescale 1ns/10ps
`include "brsc_map.svh"

module brsc_target (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    // Register contents and power state
    input brsc_pkg::brsc_regs_s regs,
    input brsc_pkg::brsc_pwr_e pwr,
    // Registered target
    output brsc_pkg::brsc_target_s target
);

    // Reset target: stage off, code zero at its own voltage, flagged low
    localparam brsc_pkg::brsc_target_s tgt_rst = '{
        code: `BRSC_RST_CODE,
        mv: `BRSC_MV_BASE,
        enable: 1'b0,
        pfm: 1'b0,
        mode: `BRSC_RST_MODE,
        low_code: 1'b1
    };

    brsc_pkg::brsc_target_s tgt_ff;
    brsc_pkg::brsc_target_s nxt_tgt;

    function automatic logic [10:0] code_to_mv(input logic [5:0] code);
        code_to_mv = `BRSC_MV_BASE + `BRSC_MV_STEP * {5'h00, code};
    endfunction

    always_comb begin
        nxt_tgt = tgt_ff;
        case (pwr)
            brsc_pkg::PWR_STANDBY: begin
                nxt_tgt.code = regs.standby_code;
            end
            brsc_pkg::PWR_SLEEP: begin
                nxt_tgt.code = regs.sleep_code;
            end
            default: begin
                nxt_tgt.code = regs.normal_code;
            end
        endcase
        nxt_tgt.mv = code_to_mv(nxt_tgt.code);
        // Sleep either turns the stage off or keeps it in PFM
        nxt_tgt.enable = (pwr != brsc_pkg::PWR_SLEEP) || regs.sleep_run_sel;
        nxt_tgt.pfm = (pwr == brsc_pkg::PWR_SLEEP) && regs.sleep_run_sel;
        nxt_tgt.mode = regs.switch_mode_sel;
        nxt_tgt.low_code = nxt_tgt.code <= `BRSC_LOW_CODE_MAX;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tgt_ff <= tgt_rst;
        end else if (en) begin
            tgt_ff <= nxt_tgt;
        end
    end

    assign target = tgt_ff;

endmodule

// [verilog/brsc_top.sv]
// Buck regulator set point and configuration bank behind an APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "brsc_map.svh"

////////////////////////////////////////////////////////////////////////////////
module brsc_top (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Power state from the sequencer
    input brsc_pkg::brsc_pwr_e POWER_STATE,
    // Regulator controls
    output brsc_pkg::brsc_cfg_s CFG_OUT,
    output brsc_pkg::brsc_target_s TARGET_OUT
);

    brsc_pkg::brsc_state_s st_ff;
    brsc_pkg::brsc_state_s nxt_st;
    logic [8:0] rd_hit_data;
    logic apb_setup;
    logic apb_access;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and register access

    function automatic logic addr_is(input logic [7:0] addr,
                                     input logic [5:0] idx);
        addr_is = (addr == {idx, 2'b00});
    endfunction

    function automatic logic [8:0] reg_read(input brsc_pkg::brsc_regs_s r,
                                            input logic [7:0] addr);
        logic [7:0] d;
        d = 8'h00;
        reg_read = 9'h000;
        if (addr_is(addr, `BRSC_IDX_NORMAL)) begin
            d[`BRSC_CODE_MSB:`BRSC_CODE_LSB] = r.normal_code;
            reg_read = {1'b1, d};
        end else if (addr_is(addr, `BRSC_IDX_STANDBY)) begin
            d[`BRSC_CODE_MSB:`BRSC_CODE_LSB] = r.standby_code;
            reg_read = {1'b1, d};
        end else if (addr_is(addr, `BRSC_IDX_SLEEP)) begin
            d[`BRSC_CODE_MSB:`BRSC_CODE_LSB] = r.sleep_code;
            reg_read = {1'b1, d};
        end else if (addr_is(addr, `BRSC_IDX_MODE)) begin
            d[`BRSC_MODE_MSB:`BRSC_MODE_LSB] = r.switch_mode_sel;
            d[`BRSC_SLEEP_RUN_BIT] = r.sleep_run_sel;
            reg_read = {1'b1, d};
        end else if (addr_is(addr, `BRSC_IDX_CONFIG)) begin
            d[`BRSC_ILIM_BIT] = r.current_limit_low;
            d[`BRSC_SPARE_BIT] = r.cfg_spare;
            d[`BRSC_FREQ_MSB:`BRSC_FREQ_LSB] = r.switch_freq_sel;
            d[`BRSC_PHASE_MSB:`BRSC_PHASE_LSB] = r.clock_phase_sel;
            d[`BRSC_RAMP_MSB:`BRSC_RAMP_LSB] = r.ramp_speed_sel;
            reg_read = {1'b1, d};
        end
    endfunction

    function automatic brsc_pkg::brsc_regs_s reg_write(
        input brsc_pkg::brsc_regs_s r,
        input logic [7:0] addr,
        input logic [7:0] d
    );
        reg_write = r;
        if (addr_is(addr, `BRSC_IDX_NORMAL)) begin
            reg_write.normal_code = d[`BRSC_CODE_MSB:`BRSC_CODE_LSB];
        end else if (addr_is(addr, `BRSC_IDX_STANDBY)) begin
            reg_write.standby_code = d[`BRSC_CODE_MSB:`BRSC_CODE_LSB];
        end else if (addr_is(addr, `BRSC_IDX_SLEEP)) begin
            reg_write.sleep_code = d[`BRSC_CODE_MSB:`BRSC_CODE_LSB];
        end else if (addr_is(addr, `BRSC_IDX_MODE)) begin
            reg_write.switch_mode_sel = d[`BRSC_MODE_MSB:`BRSC_MODE_LSB];
            reg_write.sleep_run_sel = d[`BRSC_SLEEP_RUN_BIT];
        end else if (addr_is(addr, `BRSC_IDX_CONFIG)) begin
            reg_write.current_limit_low = d[`BRSC_ILIM_BIT];
            reg_write.cfg_spare = d[`BRSC_SPARE_BIT];
            reg_write.switch_freq_sel = d[`BRSC_FREQ_MSB:`BRSC_FREQ_LSB];
            reg_write.clock_phase_sel = d[`BRSC_PHASE_MSB:`BRSC_PHASE_LSB];
            reg_write.ramp_speed_sel = d[`BRSC_RAMP_MSB:`BRSC_RAMP_LSB];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Field decoding for the analogue stage

    function automatic brsc_pkg::brsc_cfg_s cfg_of(
        input brsc_pkg::brsc_regs_s r
    );
        cfg_of = '0;
        cfg_of.current_limit_low = r.current_limit_low;
        cfg_of.switch_freq_sel = r.switch_freq_sel;
        cfg_of.clock_phase_sel = r.clock_phase_sel;
        cfg_of.ramp_speed_sel = r.ramp_speed_sel;
        case (r.switch_freq_sel)
            2'h0: begin
                cfg_of.freq_khz = `BRSC_FREQ_KHZ_0;
            end
            2'h1: begin
                cfg_of.freq_khz = `BRSC_FREQ_KHZ_1;
            end
            2'h2: begin
                cfg_of.freq_khz = `BRSC_FREQ_KHZ_2;
            end
            default: begin
                // Reserved code: no frequency, flagged to the stage
                cfg_of.freq_reserved = 1'b1;
            end
        endcase
        case (r.clock_phase_sel)
            2'h1: begin
                cfg_of.phase_deg = `BRSC_PHASE_DEG_1;
            end
            2'h2: begin
                cfg_of.phase_deg = `BRSC_PHASE_DEG_2;
            end
            2'h3: begin
                cfg_of.phase_deg = `BRSC_PHASE_DEG_3;
            end
            default: begin
                cfg_of.phase_deg = 9'h000;
            end
        endcase
        case (r.ramp_speed_sel)
            2'h0: begin
                cfg_of.ramp_step_cycles = 12'(`BRSC_RAMP_C0);
            end
            2'h1: begin
                cfg_of.ramp_step_cycles = 12'(`BRSC_RAMP_C1);
            end
            2'h2: begin
                cfg_of.ramp_step_cycles = 12'(`BRSC_RAMP_C2);
            end
            default: begin
                cfg_of.ramp_step_cycles = 12'(`BRSC_RAMP_C3);
            end
        endcase
    endfunction

    function automatic brsc_pkg::brsc_regs_s regs_reset();
        regs_reset.normal_code = `BRSC_RST_CODE;
        regs_reset.standby_code = `BRSC_RST_CODE;
        regs_reset.sleep_code = `BRSC_RST_CODE;
        regs_reset.switch_mode_sel = `BRSC_RST_MODE;
        regs_reset.sleep_run_sel = `BRSC_RST_BIT;
        regs_reset.current_limit_low = `BRSC_RST_BIT;
        regs_reset.cfg_spare = `BRSC_RST_BIT;
        regs_reset.switch_freq_sel = `BRSC_RST_FIELD;
        regs_reset.clock_phase_sel = `BRSC_RST_FIELD;
        regs_reset.ramp_speed_sel = `BRSC_RST_FIELD;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: answer registered in setup, one access cycle

    assign apb_setup = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE && st_ff.rsp.ready;
    assign rd_hit_data = reg_read(st_ff.regs, PADDR);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp = '0;
        if (apb_setup) begin
            nxt_st.rsp.ready = 1'b1;
            nxt_st.rsp.slverr = !rd_hit_data[8];
            if (!PWRITE) begin
                nxt_st.rsp.rdata = {24'h000000, rd_hit_data[7:0]};
            end
        end
        // Writes take effect only at the completing edge
        if (apb_access && PWRITE && PSTRB[0] && rd_hit_data[8]) begin
            nxt_st.regs = reg_write(st_ff.regs, PADDR, PWDATA[7:0]);
        end
        nxt_st.cfg = cfg_of(nxt_st.regs);
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_ff.regs <= regs_reset();
            st_ff.rsp <= '0;
            st_ff.cfg <= cfg_of(regs_reset());
        end else if (CLK_EN) begin
            st_ff <= nxt_st;
        end
    end

    assign PRDATA = st_ff.rsp.rdata;
    assign PREADY = st_ff.rsp.ready;
    assign PSLVERR = st_ff.rsp.slverr;
    assign CFG_OUT = st_ff.cfg;

    ////////////////////////////////////////////////////////////////////////////
    // Target selection

    brsc_target u_target (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .en(CLK_EN),
        .regs(st_ff.regs),
        .pwr(POWER_STATE),
        .target(TARGET_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [5:0] exp_code;

    always_comb begin
        case (POWER_STATE)
            brsc_pkg::PWR_STANDBY: begin
                exp_code = st_ff.regs.standby_code;
            end
            brsc_pkg::PWR_SLEEP: begin
                exp_code = st_ff.regs.sleep_code;
            end
            default: begin
                exp_code = st_ff.regs.normal_code;
            end
        endcase
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking

    default disable iff (SYS_RST);

    sequence s_setup;
        CLK_EN && PSEL && !PENABLE;
    endsequence

    sequence s_wr_access(logic [5:0] idx);
        CLK_EN && PSEL && PENABLE && PREADY && PWRITE && PSTRB[0]
            && PADDR == {idx, 2'b00};
    endsequence

    a_setup_ready: assert property (s_setup |=> PREADY)
        else $error("no ready after setup");

    a_unmapped_err: assert property (
        s_setup ##0 (PADDR[1:0] != 2'b00) |=> PREADY && PSLVERR)
        else $error("misaligned address not refused");

    a_write_normal: assert property (
        s_wr_access(`BRSC_IDX_NORMAL)
            |=> st_ff.regs.normal_code == $past(PWDATA[5:0]))
        else $error("normal set point write lost");

    a_write_standby: assert property (
        s_wr_access(`BRSC_IDX_STANDBY)
            |=> st_ff.regs.standby_code == $past(PWDATA[5:0]))
        else $error("standby set point write lost");

    a_write_sleep: assert property (
        s_wr_access(`BRSC_IDX_SLEEP)
            |=> st_ff.regs.sleep_code == $past(PWDATA[5:0]))
        else $error("sleep set point write lost");

    a_points_apart: assert property (
        s_wr_access(`BRSC_IDX_NORMAL)
            |=> $stable(st_ff.regs.standby_code)
                && $stable(st_ff.regs.sleep_code))
        else $error("set points not independent");

    a_read_unused: assert property (
        PREADY && !PSLVERR |-> PRDATA[31:8] == 24'h000000)
        else $error("upper read data not zero");

    a_mode_unused: assert property (
        s_setup ##0 !PWRITE && PADDR == {`BRSC_IDX_MODE, 2'b00}
            |=> PRDATA[7:6] == 2'h0 && !PRDATA[4]
                && PRDATA[3:0] == $past(st_ff.regs.switch_mode_sel))
        else $error("mode register read wrong");

    a_target_code: assert property (
        CLK_EN |=> TARGET_OUT.code == $past(exp_code))
        else $error("target not the active set point");

    a_sleep_state: assert property (
        CLK_EN && POWER_STATE == brsc_pkg::PWR_SLEEP
            |=> TARGET_OUT.enable == $past(st_ff.regs.sleep_run_sel)
                && TARGET_OUT.pfm == TARGET_OUT.enable)
        else $error("sleep run select not applied");

    a_mv_ends: assert property (
        (TARGET_OUT.code == 6'h00 |-> TARGET_OUT.mv == 11'h12c)
            and (TARGET_OUT.code == 6'h3f |-> TARGET_OUT.mv == 11'h753))
        else $error("voltage mapping end points wrong");

    a_low_flag: assert property (
        TARGET_OUT.low_code == (TARGET_OUT.code <= 6'h0c))
        else $error("unsupported code flag wrong");

    a_limit_cfg: assert property (
        s_wr_access(`BRSC_IDX_CONFIG)
            |=> CFG_OUT.current_limit_low == $past(PWDATA[0])
                && CFG_OUT.switch_freq_sel == $past(PWDATA[3:2]))
        else $error("config write not on outputs");

    a_freq_map: assert property (
        CFG_OUT.switch_freq_sel == 2'h3
            |-> CFG_OUT.freq_reserved && CFG_OUT.freq_khz == 12'h000)
        else $error("reserved frequency not flagged");

    a_phase_map: assert property (
        CFG_OUT.clock_phase_sel == 2'h3 |-> CFG_OUT.phase_deg == 9'h10e)
        else $error("phase mapping wrong");

    a_ramp_map: assert property (
        (CFG_OUT.ramp_speed_sel == 2'h0 |-> CFG_OUT.ramp_step_cycles == 12'h190)
            and (CFG_OUT.ramp_speed_sel == 2'h3
                |-> CFG_OUT.ramp_step_cycles == 12'hc80))
        else $error("ramp step period wrong");

    a_hold_frozen: assert property (
        !CLK_EN |=> $stable(st_ff) && $stable(TARGET_OUT))
        else $error("state moved with enable low");

endmodule
